// ===== sram_host_pkg.sv
// Constants and types shared by the SRAM host controller files
// Operation
// - Read keeps write strobe high throughout
// - Address valid before chip select falls
// - Address changes only with strobes high
// - Host never drives bus while memory drives
// - Output gate high to release data pins
// - Write cycles at least 15 ns apart
// - Write strobe low at least 10 ns
// - Select and address valid 10 ns before end
// - Twenty-bit word address on lines 0-19
package sram_host_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 40;
	localparam int WRITE_CYCLE_NS = 15;
	localparam int WRITE_PULSE_NS = 10;
	localparam int READ_CYCLE_NS = 15;
	localparam int OE_ACCESS_NS = 7;
	localparam int HIZ_NS = 7;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HIZ_CYC = (HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] WRITE_PULSE_CNT = CNT_W'(WRITE_PULSE_CYC);
	localparam logic [CNT_W-1:0] READ_CNT = CNT_W'(READ_CYCLE_CYC + 1);
	localparam logic [CNT_W-1:0] HIZ_CNT = CNT_W'(HIZ_CYC);
	localparam logic [CNT_W-1:0] RECOVER_CNT = CNT_W'(WRITE_CYCLE_CYC);

	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        lanes;
	} req_t;

	typedef struct packed {
		logic              cs_n;
		logic              we_n;
		logic              oe_n;
		logic              lb_n;
		logic              ub_n;
		logic [ADDR_W-1:0] addr;
	} strobe_t;

	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_SETUP  = 6'h02,
		ST_WPULSE = 6'h04,
		ST_READ   = 6'h08,
		ST_RELEASE= 6'h10,
		ST_RECOV  = 6'h20
	} state_t;
endpackage : sram_host_pkg

// ===== sram_sync2.sv
// Two-flop synchroniser for a data bus
module sram_sync2 #(
	parameter int W = 16
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= i_d;
			q_reg    <= meta_reg;
		end
	end

	assign o_q = q_reg;
endmodule : sram_sync2

// ===== sram_host.sv
// Host controller that runs read and write cycles on an asynchronous 16-bit SRAM
module sram_host (
	// Clock and reset
	input  wire logic                               I_CLK,
	input  wire logic                               I_RST,
	// Request side
	input  wire logic                               I_REQ_VALID,
	input  wire sram_host_pkg::req_t                I_REQ,
	output logic                                    O_REQ_READY,
	output logic                                    O_RD_VALID,
	output logic [sram_host_pkg::DATA_W-1:0]        O_RD_DATA,
	// Memory pins
	output sram_host_pkg::strobe_t                  O_MEM,
	input  wire logic [sram_host_pkg::DATA_W-1:0]   I_DQ,
	output logic [sram_host_pkg::DATA_W-1:0]        O_DQ,
	output logic [1:0]                              O_DQ_OE_N
);
	sram_host_pkg::state_t                   state_reg, state_next;
	logic [sram_host_pkg::CNT_W-1:0]         cnt_reg, cnt_next;
	sram_host_pkg::req_t                     req_reg, req_next;
	sram_host_pkg::strobe_t                  mem_reg, mem_next;
	logic [sram_host_pkg::DATA_W-1:0]        dq_reg, dq_next;
	logic [1:0]                              dqoe_reg, dqoe_next;
	logic                                    ready_reg, ready_next;
	logic                                    rdv_reg, rdv_next;
	logic [sram_host_pkg::DATA_W-1:0]        rdata_reg, rdata_next;
	logic [sram_host_pkg::DATA_W-1:0]        dq_sync;

	sram_sync2 #(.W(sram_host_pkg::DATA_W)) u_dq_sync (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.i_d   (I_DQ),
		.o_q   (dq_sync)
	);

	logic                                    take;
	logic                                    cnt_done;
	logic                                    wp_end;
	logic                                    rd_end;

	// Shared decode of the sequencer position
	assign take     = (state_reg == sram_host_pkg::ST_IDLE) && I_REQ_VALID && ready_reg;
	assign cnt_done = (cnt_reg == '0);
	// A write pulse ends on its last counted cycle
	assign wp_end   = (state_reg == sram_host_pkg::ST_WPULSE) && (cnt_reg <= 4'h1);
	assign rd_end   = (state_reg == sram_host_pkg::ST_READ) && cnt_done;

	// Sequencer: state, cycle counter, request latch and ready flag
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		req_next   = req_reg;
		ready_next = ready_reg;
		// Counter runs down to zero and then rests
		if (!cnt_done) begin
			cnt_next = cnt_reg - 1'h1;
		end

		case (state_reg)
			sram_host_pkg::ST_IDLE: begin
				// A request is taken only while the port is idle and offered
				if (take) begin
					req_next   = I_REQ;
					ready_next = 1'h0;
					state_next = sram_host_pkg::ST_SETUP;
				end
			end
			sram_host_pkg::ST_SETUP: begin
				// Counts cover pulse width, access time and the synchroniser
				if (req_reg.write) begin
					cnt_next   = sram_host_pkg::WRITE_PULSE_CNT;
					state_next = sram_host_pkg::ST_WPULSE;
				end else begin
					cnt_next   = sram_host_pkg::READ_CNT;
					state_next = sram_host_pkg::ST_READ;
				end
			end
			sram_host_pkg::ST_WPULSE: begin
				// Recovery keeps the next address change clear of this write
				if (wp_end) begin
					cnt_next   = sram_host_pkg::RECOVER_CNT;
					state_next = sram_host_pkg::ST_RECOV;
				end
			end
			sram_host_pkg::ST_READ: begin
				if (rd_end) begin
					// Give the memory its turn-off time before the bus is offered again
					cnt_next   = sram_host_pkg::HIZ_CNT;
					state_next = sram_host_pkg::ST_RELEASE;
				end
			end
			sram_host_pkg::ST_RELEASE: begin
				if (cnt_done) begin
					ready_next = 1'h1;
					state_next = sram_host_pkg::ST_IDLE;
				end
			end
			sram_host_pkg::ST_RECOV: begin
				if (cnt_done) begin
					ready_next = 1'h1;
					state_next = sram_host_pkg::ST_IDLE;
				end
			end
			default: begin
				// Unknown state: return to idle and offer the port again
				ready_next = 1'h1;
				state_next = sram_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_reg <= sram_host_pkg::ST_IDLE;
			cnt_reg   <= '0;
			req_reg   <= '0;
			ready_reg <= 1'h1;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			req_reg   <= req_next;
			ready_reg <= ready_next;
		end
	end

	// Memory pins: address, strobes, write data and its lane drivers
	always_comb begin
		mem_next  = mem_reg;
		dq_next   = dq_reg;
		dqoe_next = dqoe_reg;
		case (state_reg)
			sram_host_pkg::ST_IDLE: begin
				if (take) begin
					// Address settles while all strobes stay high
					mem_next.addr = I_REQ.addr;
				end
			end
			sram_host_pkg::ST_SETUP: begin
				mem_next.cs_n = 1'h0;
				mem_next.lb_n = ~req_reg.lanes[0];
				mem_next.ub_n = ~req_reg.lanes[1];
				if (req_reg.write) begin
					mem_next.we_n = 1'h0;
					mem_next.oe_n = 1'h1;
					dq_next       = req_reg.wdata;
					// Drive from the same edge as the low strobe; the high output gate has already floated the memory
					dqoe_next     = ~req_reg.lanes;
				end else begin
					mem_next.we_n = 1'h1;
					mem_next.oe_n = 1'h0;
					dqoe_next     = 2'h3;
				end
			end
			sram_host_pkg::ST_WPULSE: begin
				if (wp_end) begin
					// Strobe and select rise together; data held one more cycle
					mem_next.we_n = 1'h1;
					mem_next.cs_n = 1'h1;
					mem_next.lb_n = 1'h1;
					mem_next.ub_n = 1'h1;
				end
			end
			sram_host_pkg::ST_READ: begin
				if (rd_end) begin
					// Close the access; the memory still owns the bus for its turn-off time
					mem_next.oe_n = 1'h1;
					mem_next.cs_n = 1'h1;
					mem_next.lb_n = 1'h1;
					mem_next.ub_n = 1'h1;
				end
			end
			sram_host_pkg::ST_RECOV: begin
				// Write data held past the strobe edge, then released
				dqoe_next = 2'h3;
			end
			default: begin
				// Any other state leaves the bus to the memory
				dqoe_next = 2'h3;
			end
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			mem_reg  <= '{cs_n: 1'h1, we_n: 1'h1, oe_n: 1'h1, lb_n: 1'h1, ub_n: 1'h1, addr: '0};
			dq_reg   <= '0;
			dqoe_reg <= 2'h3;
		end else begin
			mem_reg  <= mem_next;
			dq_reg   <= dq_next;
			dqoe_reg <= dqoe_next;
		end
	end

	// Read response: data captured from the synchronised bus at the end of the access
	// Valid pulses for one cycle; data holds until the next read
	always_comb begin
		rdv_next   = 1'h0;
		rdata_next = rdata_reg;
		if (rd_end) begin
			rdata_next = dq_sync;
			rdv_next   = 1'h1;
		end
	end

	always_ff @(posedge I_CLK or posedge I_RST) begin
		if (I_RST) begin
			rdv_reg   <= 1'h0;
			rdata_reg <= '0;
		end else begin
			rdv_reg   <= rdv_next;
			rdata_reg <= rdata_next;
		end
	end

	// Every output is a register
	assign O_REQ_READY = ready_reg;
	assign O_RD_VALID  = rdv_reg;
	assign O_RD_DATA   = rdata_reg;
	assign O_MEM       = mem_reg;
	assign O_DQ        = dq_reg;
	assign O_DQ_OE_N   = dqoe_reg;
endmodule : sram_host

// ===== sram_host_asserts.sv
// Pin protocol checker for the SRAM host controller
module sram_host_asserts (
	// Clock and reset
	input  wire logic                   I_CLK,
	input  wire logic                   I_RST,
	// Request side and memory pins
	input  wire logic                   I_REQ_VALID,
	input  wire sram_host_pkg::req_t    I_REQ,
	input  wire logic                   O_REQ_READY,
	input  wire sram_host_pkg::strobe_t O_MEM,
	input  wire logic [1:0]             O_DQ_OE_N
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	wire take = I_REQ_VALID && O_REQ_READY;
	sequence s_pulse; !O_MEM.we_n && !O_MEM.cs_n ##1 O_MEM.we_n; endsequence
	sequence s_gap; O_MEM.we_n [*4]; endsequence
	AST_RD_WE: assert property (!O_MEM.oe_n |-> O_MEM.we_n) else $error("strobe low in read");
	AST_ADDR_CS: assert property ($fell(O_MEM.cs_n) |-> $stable(O_MEM.addr)) else $error("addr moved");
	AST_ADDR_CHG: assert property (!$stable(O_MEM.addr) |-> O_MEM.cs_n || O_MEM.we_n) else $error("addr");
	AST_BUS: assert property (O_DQ_OE_N != 2'h3 |-> O_MEM.oe_n) else $error("bus clash");
	AST_WP: assert property ($fell(O_MEM.we_n) |-> s_pulse) else $error("write pulse");
	AST_WEND: assert property ($rose(O_MEM.we_n) |-> !$past(O_MEM.cs_n) && $stable(O_MEM.addr)) else $error("end");
	AST_WGAP: assert property ($rose(O_MEM.we_n) |-> s_gap) else $error("write gap");
	AST_ADDR: assert property (take |=> O_MEM.addr == $past(I_REQ.addr)) else $error("addr value");
endmodule : sram_host_asserts

bind sram_host sram_host_asserts sram_host_asserts_i (.I_CLK(I_CLK), .I_RST(I_RST), .I_REQ_VALID(I_REQ_VALID),
	.I_REQ(I_REQ), .O_REQ_READY(O_REQ_READY), .O_MEM(O_MEM), .O_DQ_OE_N(O_DQ_OE_N));

// ===== sram_model.sv
// Behavioural asynchronous 16-bit SRAM
module sram_model (
	// Memory pins
	input  wire sram_host_pkg::strobe_t i_mem,
	input  wire logic [15:0]            i_dq,
	output logic [15:0]                 o_dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:(1 << sram_host_pkg::ADDR_W) - 1];
	logic [15:0] last = 16'h0;
	wire  [1:0]  lane_n = {i_mem.ub_n, i_mem.lb_n};
	wire  [1:0]  en = {2{!i_mem.cs_n && !i_mem.oe_n && i_mem.we_n}} & ~lane_n;
	always @* begin
		for (int k = 0; k < 2; k++) begin
			if (!i_mem.cs_n && !i_mem.we_n && !lane_n[k]) mem[i_mem.addr][k*8+:8] = i_dq[k*8+:8];
			if (en[k]) last[k*8+:8] = mem[i_mem.addr][k*8+:8];
		end
	end
	// Released lanes show the inverse of the last driven value
	always @* begin
		for (int k = 0; k < 2; k++) o_dq[k*8+:8] = en[k] ? mem[i_mem.addr][k*8+:8] : ~last[k*8+:8];
	end
endmodule : sram_model

// ===== sram_host_tb_top.sv
// Self-checking bench for the SRAM host controller
module sram_host_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                   clk = 0, rst = 1, vld = 0, rdy, rdv;
	sram_host_pkg::req_t    rq = '0;
	sram_host_pkg::strobe_t pins;
	logic [15:0]            rdat, hdq, dq, mdq, sh [int], q [$];
	logic [1:0]             oe_n;
	logic [19:0]            a [8];
	int                     errors = 0, num_checks = 0, seed = 32'h0524;
	always #20 clk = ~clk;
	assign dq[7:0] = oe_n[0] ? mdq[7:0] : hdq[7:0];
	assign dq[15:8] = oe_n[1] ? mdq[15:8] : hdq[15:8];
	sram_host sram_host_i (.I_CLK(clk), .I_RST(rst), .I_REQ_VALID(vld), .I_REQ(rq), .O_REQ_READY(rdy),
		.O_RD_VALID(rdv), .O_RD_DATA(rdat), .O_MEM(pins), .I_DQ(dq), .O_DQ(hdq), .O_DQ_OE_N(oe_n));
	sram_model sram_model_i (.i_mem(pins), .i_dq(dq), .o_dq(mdq));
	task automatic chk(input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (e !== g) begin
			errors++;
			$display("Error O_RD_DATA expected %h seen %h", e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : final_report
	task automatic req(input logic w, input logic [19:0] ad, input logic [15:0] d, input logic [1:0] l);
		int          n = 0;
		logic [15:0] m = {{8{l[1]}}, {8{l[0]}}};
		while (rdy !== 1'h1 && n < 20) begin
			@(negedge clk);
			n++;
		end
		if (n == 20) begin
			errors++;
			$display("Error O_REQ_READY expected 1 seen %b", rdy);
		end
		vld = 1;
		rq = '{w, ad, d, l};
		@(posedge clk);
		@(negedge clk);
		vld = 0;
		if (w) sh[ad] = (sh[ad] & ~m) | (d & m);
		else q.push_back(sh[ad]);
	endtask : req
	always @(posedge clk) begin
		if (rdv === 1'b1) begin
			if (q.size() == 0) begin
				errors++;
				$display("Error O_RD_VALID expected 0 seen %b", rdv);
			end else chk(q.pop_front(), rdat);
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst = 0;
		// Full write then a back-to-back partial overwrite with every lane code
		for (int i = 0; i < 8; i++) begin
			a[i] = i ? 20'($random(seed)) : 20'hfffff;
			req(1, a[i], 16'($random(seed)), 2'h3);
			req(1, a[i], 16'($random(seed)), i[1:0]);
		end
		$display("write test done");
		for (int i = 0; i < 8; i++) req(0, a[i], 16'h0, 2'h3);
		repeat (10) @(negedge clk);
		errors += q.size();
		$display("read test done");
		final_report();
	end
	initial begin
		#(40 * 2000);
		errors++;
		final_report();
	end
endmodule : sram_host_tb_top
